// *** core/mrb_evt_if.sv ***
// interface between the latch units and the top
`timescale 1ns/1ps
interface mrb_evt_if #(parameter int W = 3);
    logic         rd;
    logic         evt_hi;
    logic         evt_lo_n;
    logic [W-1:0] state;
    logic         lh;
    logic         ll;
    logic [W-1:0] latch_max_group;
    modport top  (output rd, evt_hi, evt_lo_n, state,
                  input lh, ll, latch_max_group);
    modport unit (input rd, evt_hi, evt_lo_n, state,
                  output lh, ll, latch_max_group);
endinterface

// *** core/mrb_latch_unit.sv ***
// latching-high, latching-low and latching-maximum bits
`timescale 1ns/1ps
`include "mrb_regs.svh"
module mrb_latch_unit #(
    parameter int W = `MRB_LMX_WIDTH
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    mrb_evt_if.unit   bus
);
    // refuse a group the compare logic cannot serve
    if (W < 1) begin
        $error("W must be at least 1");
    end

    function automatic logic [W-1:0] max_of(input logic [W-1:0] a,
                                            input logic [W-1:0] b);
        max_of = (a > b) ? a : b;
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bus.lh <= `MRB_LH_RST;
        end else if (bus.rd) begin
            bus.lh <= bus.evt_hi;
        end else if (bus.evt_hi) begin
            bus.lh <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bus.ll <= `MRB_LL_RST;
        end else if (bus.rd) begin
            bus.ll <= bus.evt_lo_n;
        end else if (!bus.evt_lo_n) begin
            bus.ll <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bus.latch_max_group <= W'(`MRB_LMX_RST);
        end else if (bus.rd) begin
            bus.latch_max_group <= bus.state;
        end else begin
            bus.latch_max_group <= max_of(bus.latch_max_group, bus.state);
        end
    end
endmodule

// *** core/mrb_pkg.sv ***
// types for the management register bit-behaviour block
package mrb_pkg;
    typedef enum logic [1:0] {
        MRB_SC_IDLE,
        MRB_SC_RUN,
        MRB_SC_DONE
    } mrb_sc_state_t;
endpackage

// *** core/mrb_regs.svh ***
// constants for the management register bit-behaviour block
`ifndef MRB_REGS_SVH
`define MRB_REGS_SVH
`define MRB_LH_RST      1'b0
`define MRB_LL_RST      1'b1
`define MRB_SC_RST      1'b0
`define MRB_LMX_WIDTH   3
`define MRB_LMX_RST     3'h0
`define MRB_ADDR_WIDTH  5
`define MRB_DEF_WIDTH   16
`define MRB_DEF_VALUE   16'h0000
`define MRB_SC_CYCLES   16
`endif

// *** core/mrb_self_clear.sv ***
// self-clearing trigger bit with its function sequencer
`timescale 1ns/1ps
`include "mrb_regs.svh"
module mrb_self_clear #(
    parameter int RUN_CYCLES = `MRB_SC_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_wr_one,
    output logic      o_bit,
    output logic      o_busy
);
    localparam int CW = $clog2(RUN_CYCLES + 1);
    mrb_pkg::mrb_sc_state_t state_reg;
    logic [CW-1:0]          cnt_reg;

    // a zero-length run would load a negative count of RUN_CYCLES - 1
    if (RUN_CYCLES < 1) begin
        $error("RUN_CYCLES must be at least 1");
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg <= mrb_pkg::MRB_SC_IDLE;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                mrb_pkg::MRB_SC_IDLE: begin
                    if (i_wr_one) begin
                        state_reg <= mrb_pkg::MRB_SC_RUN;
                        cnt_reg   <= CW'(RUN_CYCLES - 1);
                    end
                end
                mrb_pkg::MRB_SC_RUN: begin
                    if (cnt_reg == '0) begin
                        state_reg <= mrb_pkg::MRB_SC_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - CW'(1);
                    end
                end
                mrb_pkg::MRB_SC_DONE: begin
                    state_reg <= mrb_pkg::MRB_SC_IDLE;
                end
                default: begin
                    state_reg <= mrb_pkg::MRB_SC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_bit  <= `MRB_SC_RST;
            o_busy <= 1'b0;
        end else if (state_reg == mrb_pkg::MRB_SC_IDLE && i_wr_one) begin
            o_bit  <= 1'b1;
            o_busy <= 1'b1;
        end else if (state_reg == mrb_pkg::MRB_SC_RUN && cnt_reg == '0) begin
            o_bit  <= 1'b0;
            o_busy <= 1'b0;
        end
    end
endmodule

// *** core/mrb_top.sv ***
// management register bit-behaviour block: defaults, latches, self-clear
// Overview of operation
// - every register bit with a default takes that default on reset.
// - pin-strapped bits take the level sampled on their pin at reset.
// - a latch-high bit captures one when its event input goes high.
// - a latch-high bit at one stays one until reset or a read.
// - after a read a latch-high bit reloads the event's present level.
// - a latch-low bit captures zero when its event input goes low.
// - a latch-low bit at zero stays zero until reset or a read.
// - after a read a latch-low bit reloads the event's present level.
// - a latch-max group stores a new state only if it is larger.
// - a latch-max group holds its maximum until reset or a read.
// - after a read a latch-max group reloads the present state.
// - self-clear bits are zero out of reset.
// - writing one to a self-clear bit starts its function, except while busy and in the cycle after the bit clears.
// - the self-clear bit returns to zero when the function ends.
`timescale 1ns/1ps
`include "mrb_regs.svh"
module mrb_top #(
    parameter int              LMX_W      = `MRB_LMX_WIDTH,
    parameter int              SC_CYCLES  = `MRB_SC_CYCLES,
    parameter logic [15:0]     DEF_VALUE  = `MRB_DEF_VALUE
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // strap pins, asynchronous
    input  wire logic             i_phy_addr0_led_pin,
    input  wire logic             i_phy_addr1_led_pin,
    input  wire logic             i_phy_addr2_led_pin,
    input  wire logic             i_phy_addr3_led_pin,
    input  wire logic             i_phy_addr4_led_pin,
    // management access strobes
    input  wire logic             i_rd_status,
    input  wire logic             i_wr_sc_one,
    input  wire logic             i_wr_def,
    input  wire logic [15:0]      i_wr_def_data,
    // monitored internal signals
    input  wire logic             i_evt_hi,
    input  wire logic             i_evt_lo_n,
    input  wire logic [LMX_W-1:0] i_fsm_state,
    // register bits
    output logic [4:0]            o_phy_addr,
    output logic [15:0]           o_def_reg,
    output logic                  o_latch_high_bit,
    output logic                  o_latch_low_bit,
    output logic [LMX_W-1:0]      o_latch_max_group,
    output logic                  o_self_clear_bit,
    output logic                  o_sc_busy
);
    // group must fit a 16-bit register
    if (LMX_W < 1 || LMX_W > 16) begin
        $error("LMX_W out of range");
    end

    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic       rst_d_reg;
    logic       sc_bit;
    logic       sc_busy;

    mrb_evt_if #(.W(LMX_W)) evt ();

    assign evt.rd       = i_rd_status;
    assign evt.evt_hi   = i_evt_hi;
    assign evt.evt_lo_n = i_evt_lo_n;
    assign evt.state    = i_fsm_state;

    // strap synchroniser
    always_ff @(posedge i_core_clk) begin
        pin_s1_reg <= {i_phy_addr4_led_pin, i_phy_addr3_led_pin,
                       i_phy_addr2_led_pin, i_phy_addr1_led_pin,
                       i_phy_addr0_led_pin};
        pin_s2_reg <= pin_s1_reg;
    end

    // capture straps while reset is held and on its release edge
    always_ff @(posedge i_core_clk) begin
        rst_d_reg <= i_rst;
        if (i_rst || rst_d_reg) begin
            o_phy_addr <= pin_s2_reg;
        end
    end

    // ordinary bit with a fixed default; reserved bits are
    // trusted to be written back at their defaults
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_def_reg <= DEF_VALUE;
        end else if (i_wr_def) begin
            o_def_reg <= i_wr_def_data;
        end
    end

    mrb_latch_unit #(
        .W(LMX_W)
    ) u_latch (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .bus        (evt.unit)
    );

    mrb_self_clear #(
        .RUN_CYCLES(SC_CYCLES)
    ) u_sc (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr_one   (i_wr_sc_one),
        .o_bit      (sc_bit),
        .o_busy     (sc_busy)
    );

    assign o_latch_high_bit  = evt.lh;
    assign o_latch_low_bit   = evt.ll;
    assign o_latch_max_group = evt.latch_max_group;
    assign o_self_clear_bit  = sc_bit;
    assign o_sc_busy         = sc_busy;
endmodule

// *** verification/mrb_station_model.sv ***
// station model driving management access strobes
`timescale 1ns/1ps
module mrb_station_model #(
    parameter logic [15:0] RSVD_MASK = 16'h00FF,
    parameter logic [15:0] RSVD_DEF  = 16'h0000
) (
    // access strobes
    output logic        o_rd,
    output logic        o_wr_sc,
    output logic        o_wr_def,
    output logic [15:0] o_wr_def_data
);
    initial begin
        {o_rd, o_wr_sc, o_wr_def} = 3'h0;
        o_wr_def_data = 16'h0000;
    end
    // call at a falling edge; levels stand until the next call
    task automatic put(input logic rd, sc, wd, input logic [15:0] d);
        {o_rd, o_wr_sc, o_wr_def} = {rd, sc, wd};
        if (wd) begin
            o_wr_def_data = (d & ~RSVD_MASK) | (RSVD_DEF & RSVD_MASK);
        end else begin
            o_wr_def_data = ~o_wr_def_data;
        end
    endtask
endmodule

// *** verification/mrb_top_assertions.sv ***
// checker for latch and self-clear behaviour of mrb_top
`timescale 1ns/1ps
module mrb_top_assertions #(
    parameter int LMX_W     = 3,
    parameter int SC_CYCLES = 16
) (
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic             i_rd_status,
    input wire logic             i_wr_sc_one,
    input wire logic             i_evt_hi,
    input wire logic             i_evt_lo_n,
    input wire logic [LMX_W-1:0] i_fsm_state,
    input wire logic             o_latch_high_bit,
    input wire logic             o_latch_low_bit,
    input wire logic [LMX_W-1:0] o_latch_max_group,
    input wire logic             o_self_clear_bit,
    input wire logic             o_sc_busy
);
    localparam int SC_HI = SC_CYCLES - 1;
    logic [LMX_W-1:0] lmx_exp;
    // larger of stored maximum and present state
    assign lmx_exp = (i_fsm_state > o_latch_max_group) ? i_fsm_state
                                                      : o_latch_max_group;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence sc_start;
        i_wr_sc_one && !o_sc_busy && !$past(o_sc_busy);
    endsequence
    sequence sc_run;
        o_self_clear_bit throughout (1'b1 ##SC_HI 1'b1);
    endsequence
    a_lh_sets: assert property (
        i_evt_hi |=> o_latch_high_bit)
        else $error("latch high bit missed event");
    a_lh_holds: assert property (
        !i_rd_status && o_latch_high_bit |=> o_latch_high_bit)
        else $error("latch high bit dropped");
    a_lh_reload: assert property (
        i_rd_status |=> o_latch_high_bit == $past(i_evt_hi))
        else $error("latch high reload wrong");
    a_ll_clears: assert property (
        !i_evt_lo_n |=> !o_latch_low_bit)
        else $error("latch low bit missed event");
    a_ll_holds: assert property (
        !i_rd_status && !o_latch_low_bit |=> !o_latch_low_bit)
        else $error("latch low bit rose");
    a_ll_reload: assert property (
        i_rd_status |=> o_latch_low_bit == $past(i_evt_lo_n))
        else $error("latch low reload wrong");
    a_lmx_track: assert property (
        !i_rd_status |=> o_latch_max_group == $past(lmx_exp))
        else $error("latch max group wrong");
    a_lmx_reload: assert property (
        i_rd_status |=> o_latch_max_group == $past(i_fsm_state))
        else $error("latch max reload wrong");
    a_sc_clears: assert property (
        sc_start |=> sc_run ##1 !o_self_clear_bit)
        else $error("self-clear bit timing wrong");
endmodule
bind mrb_top mrb_top_assertions #(
    .LMX_W     (LMX_W),
    .SC_CYCLES (SC_CYCLES)
) mrb_top_assertions_inst (
    .i_core_clk        (i_core_clk),
    .i_rst             (i_rst),
    .i_rd_status       (i_rd_status),
    .i_wr_sc_one       (i_wr_sc_one),
    .i_evt_hi          (i_evt_hi),
    .i_evt_lo_n        (i_evt_lo_n),
    .i_fsm_state       (i_fsm_state),
    .o_latch_high_bit  (o_latch_high_bit),
    .o_latch_low_bit   (o_latch_low_bit),
    .o_latch_max_group (o_latch_max_group),
    .o_self_clear_bit  (o_self_clear_bit),
    .o_sc_busy         (o_sc_busy)
);

// *** verification/mrb_top_tb_top.sv ***
// self-checking bench for mrb_top
`timescale 1ns/1ps
module mrb_top_tb_top;
    localparam int SCN = 2;
    logic        i_core_clk = 1'b0;
    logic        i_rst      = 1'b1;
    logic [4:0]  pins       = 5'h15;
    logic        evt_hi     = 1'b0;
    logic        evt_lo_n   = 1'b1;
    logic [2:0]  fsm        = 3'h0;
    logic        rd, wr_sc, wr_def, lh, ll, scb, busy;
    logic [15:0] wdat, def_reg;
    logic [4:0]  phy;
    logic [2:0]  latch_max_group;
    int          bad_count    = 0;
    int          total_checks = 0;
    logic [5:0]  stim [7] = '{6'h36, 6'h14, 6'h08, 6'h13, 6'h2B, 6'h11, 6'h1E};
    logic [4:0]  expv [7] = '{5'h1B, 5'h1B, 5'h14, 5'h09, 5'h15, 5'h08, 5'h0F};
    always #5 i_core_clk = ~i_core_clk;
    mrb_station_model mrb_station_model_inst (.o_rd(rd), .o_wr_sc(wr_sc),
        .o_wr_def(wr_def), .o_wr_def_data(wdat));
    mrb_top #(.SC_CYCLES(SCN)) mrb_top_inst (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_phy_addr0_led_pin(pins[0]),
        .i_phy_addr1_led_pin(pins[1]), .i_phy_addr2_led_pin(pins[2]),
        .i_phy_addr3_led_pin(pins[3]), .i_phy_addr4_led_pin(pins[4]),
        .i_rd_status(rd), .i_wr_sc_one(wr_sc), .i_wr_def(wr_def),
        .i_wr_def_data(wdat), .i_evt_hi(evt_hi), .i_evt_lo_n(evt_lo_n),
        .i_fsm_state(fsm), .o_phy_addr(phy), .o_def_reg(def_reg),
        .o_latch_high_bit(lh), .o_latch_low_bit(ll),
        .o_latch_max_group(latch_max_group), .o_self_clear_bit(scb), .o_sc_busy(busy));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic st(input logic rd_v, sc_v, wd_v, input logic [15:0] d);
        mrb_station_model_inst.put(rd_v, sc_v, wd_v, d);
    endtask
    task automatic rst_check(input logic [4:0] p);
        chk(def_reg, 16'h0000);
        chk({lh, ll, latch_max_group}, 5'h08);
        chk(scb, 1'b0);
        chk(phy, p);
    endtask
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
    initial begin
        cyc(16);
        i_rst = 1'b0;
        cyc(1);
        rst_check(5'h15);
        pins = 5'h0A;
        cyc(3);
        chk(phy, 5'h15);
        $display("reset test done");
        for (int i = 0; i < 7; i++) begin
            {evt_hi, evt_lo_n, fsm} = stim[i][5:1];
            st(stim[i][0], 1'b0, 1'b0, 16'h0000);
            cyc(1);
            chk({lh, ll, latch_max_group}, expv[i]);
        end
        {evt_hi, evt_lo_n, fsm} = 5'h08;
        $display("latch table done");
        st(1'b0, 1'b1, 1'b0, 16'h0000);
        cyc(1);
        chk({scb, busy}, 2'h3);
        // second write while busy must not restart
        cyc(1);
        chk({scb, busy}, 2'h3);
        st(1'b0, 1'b0, 1'b0, 16'h0000);
        cyc(1);
        chk({scb, busy}, 2'h0);
        cyc(SCN - 1);
        chk({scb, busy}, 2'h0);
        st(1'b0, 1'b0, 1'b1, 16'hA5C3);
        cyc(1);
        st(1'b0, 1'b0, 1'b0, 16'h0000);
        chk(def_reg, 16'hA500);
        $display("self-clear and write test done");
        evt_hi = 1'b1;
        cyc(1);
        evt_hi = 1'b0;
        i_rst = 1'b1;
        cyc(4);
        i_rst = 1'b0;
        cyc(1);
        rst_check(5'h0A);
        $display("second reset test done");
        final_report();
    end
endmodule
